// [design/bitproc_pkg.sv]
// What this block does
// - Set, clear, complement of an addressed bit: two bytes, one cycle, set=1, clear=0
// - One-byte set, clear, complement act directly on the carry
// - Bit address D5 hex is bit 5 of the status word (user flag)
// - Bit move: bit to carry in one cycle, carry to bit in two
// - Four ops AND or OR the carry with a bit, result in carry
// - Inverted variants use the complemented bit; source bit never changes
// - Jump if carry one, jump if carry zero
// - Three-byte jumps test any bit for one or zero
// - Jump-if-set-and-clear branches on one and clears the bit, two cycles
// - All conditional jumps are relative and take two cycles
// - Target is incremented counter plus signed last byte; zero means next
// - Unconditional short jump uses the same relative offset
// - Rotate through carry and addition, with carry-in, also update carry
// - All eight status word bits, parity and overflow included, are testable
// - Port output bits complement in one cycle; port lines testable by jumps
// - Bit addresses 0..127 map onto RAM bytes 20..2F hex, low bit first
// - Bit addresses 128..255 pick register at upper five bits, low three select bit
// - Carry is status word bit 7; byte writes there change the carry
package bitproc_pkg;

	typedef enum logic [4:0] {
		OP_SET_BIT = 5'h00, OP_CLR_BIT = 5'h01, OP_CPL_BIT = 5'h02,
		OP_SET_C = 5'h03, OP_CLR_C = 5'h04, OP_CPL_C = 5'h05,
		OP_MOV_C_BIT = 5'h06, OP_MOV_BIT_C = 5'h07,
		OP_AND_C_BIT = 5'h08, OP_AND_C_NBIT = 5'h09,
		OP_OR_C_BIT = 5'h0A, OP_OR_C_NBIT = 5'h0B,
		OP_JUMP_C = 5'h0C, OP_JUMP_NC = 5'h0D,
		OP_JUMP_BIT = 5'h0E, OP_JUMP_NBIT = 5'h0F, OP_JUMP_CLR = 5'h10,
		OP_SHORT_JUMP = 5'h11, OP_ROT_LEFT_C = 5'h12, OP_ROT_RIGHT_C = 5'h13,
		OP_ADD_IMM = 5'h14, OP_ADD_WITH_CARRY_OP_IMM = 5'h15, OP_MOV_DIR_IMM = 5'h16
	} bit_op_e;

	typedef struct packed {
		bit_op_e op;
		logic [7:0] bit_addr;
		logic [7:0] operand;
	} instr_s;

	typedef enum logic {ST_FIRST = 1'b0, ST_SECOND = 1'b1} exec_state_e;

	localparam logic [7:0] RAM_BYTE_BASE = 8'h20;
	localparam logic [3:0] RAM_PAGE = 4'h2;
	localparam int RAM_BYTES = 16;
	localparam logic [7:0] ADDR_P1 = 8'h90;
	localparam logic [7:0] ADDR_TCON = 8'h88;
	localparam logic [7:0] ADDR_PSW = 8'hD0;
	localparam logic [7:0] ADDR_ACC = 8'hE0;
	localparam logic [7:0] ADDR_B = 8'hF0;
	localparam logic [7:0] UNMAPPED_READ = 8'h00;
	localparam int PSW_CY = 7;
	localparam int PSW_AC = 6;
	localparam int PSW_OV = 2;
	localparam int PSW_P = 0;
	localparam int SFR_SELECT_BIT = 7;
	localparam logic [7:0] PSW_RESET = 8'h00;
	localparam logic [7:0] P1_RESET = 8'hFF;
	localparam logic [7:0] BYTE_RESET = 8'h00;
	localparam logic [15:0] PC_RESET = 16'h0000;
	localparam logic [1:0] LEN_ONE = 2'h1;
	localparam logic [1:0] LEN_TWO = 2'h2;
	localparam logic [1:0] LEN_THREE = 2'h3;

endpackage : bitproc_pkg

// [design/bit_processor.sv]
`timescale 1ns/1ps
`default_nettype none
module bit_processor (
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic ce,
	input wire logic instr_valid,
	input wire bitproc_pkg::instr_s instr,
	output logic instr_ready,
	input wire logic [7:0] p1_pin,
	output logic [7:0] p1_out,
	output logic [7:0] acc,
	output logic [7:0] program_status_word,
	output logic carry_flag,
	output logic [15:0] pc,
	output logic done,
	output logic branch_taken
);

	// ==========================================
	// Opcode properties
	function automatic logic [1:0] len_of(input bitproc_pkg::bit_op_e op);
		unique case (op)
			bitproc_pkg::OP_SET_C, bitproc_pkg::OP_CLR_C, bitproc_pkg::OP_CPL_C,
			bitproc_pkg::OP_ROT_LEFT_C, bitproc_pkg::OP_ROT_RIGHT_C:
				len_of = bitproc_pkg::LEN_ONE;
			bitproc_pkg::OP_JUMP_BIT, bitproc_pkg::OP_JUMP_NBIT, bitproc_pkg::OP_JUMP_CLR,
			bitproc_pkg::OP_MOV_DIR_IMM:
				len_of = bitproc_pkg::LEN_THREE;
			default: len_of = bitproc_pkg::LEN_TWO;
		endcase
	endfunction : len_of

	function automatic logic is_two(input bitproc_pkg::bit_op_e op);
		unique case (op)
			bitproc_pkg::OP_MOV_BIT_C, bitproc_pkg::OP_JUMP_C, bitproc_pkg::OP_JUMP_NC,
			bitproc_pkg::OP_JUMP_BIT, bitproc_pkg::OP_JUMP_NBIT, bitproc_pkg::OP_JUMP_CLR,
			bitproc_pkg::OP_SHORT_JUMP, bitproc_pkg::OP_MOV_DIR_IMM:
				is_two = 1'b1;
			default: is_two = 1'b0;
		endcase
	endfunction : is_two

	// ==========================================
	// State
	bitproc_pkg::exec_state_e state_q;
	bitproc_pkg::instr_s hold_q;
	logic [7:0] ram_q [bitproc_pkg::RAM_BYTES];
	logic [7:0] acc_q, b_q, psw_q, p1_q, tcon_q;
	logic [15:0] pc_q;
	logic done_q, taken_q;

	// ==========================================
	// Sequencing: two-cycle ops are parked and finish in the second cycle
	wire in_second = (state_q == bitproc_pkg::ST_SECOND);
	wire accept = ce & instr_valid & ~in_second;
	wire accept_two = accept & is_two(instr.op);
	wire exec = in_second ? ce : (accept & ~is_two(instr.op));
	bitproc_pkg::instr_s cur;
	assign cur = in_second ? hold_q : instr;

	// ==========================================
	// Bit address decode
	wire is_ram = ~cur.bit_addr[bitproc_pkg::SFR_SELECT_BIT];
	wire [3:0] ram_idx = cur.bit_addr[6:3];
	wire [2:0] bit_pos = cur.bit_addr[2:0];
	wire [7:0] sfr_addr = {cur.bit_addr[7:3], 3'b000};

	// Latch view feeds read-modify-write; pin view feeds tests so lines can be polled
	wire [7:0] sfr_latch =
		(sfr_addr == bitproc_pkg::ADDR_ACC) ? acc_q :
		(sfr_addr == bitproc_pkg::ADDR_B) ? b_q :
		(sfr_addr == bitproc_pkg::ADDR_PSW) ? psw_q :
		(sfr_addr == bitproc_pkg::ADDR_P1) ? p1_q :
		(sfr_addr == bitproc_pkg::ADDR_TCON) ? tcon_q : bitproc_pkg::UNMAPPED_READ;
	wire [7:0] sfr_pin = (sfr_addr == bitproc_pkg::ADDR_P1) ? p1_pin : sfr_latch;
	wire [7:0] byte_old = is_ram ? ram_q[ram_idx] : sfr_latch;
	wire bit_test = is_ram ? ram_q[ram_idx][bit_pos] : sfr_pin[bit_pos];
	wire cy = psw_q[bitproc_pkg::PSW_CY];

	// ==========================================
	// Arithmetic for add and add-with-carry
	wire cin = (cur.op == bitproc_pkg::OP_ADD_WITH_CARRY_OP_IMM) & cy;
	wire [8:0] sum9 = {1'b0, acc_q} + {1'b0, cur.operand} + {8'h00, cin};
	wire [4:0] half5 = {1'b0, acc_q[3:0]} + {1'b0, cur.operand[3:0]} + {4'h0, cin};
	wire [7:0] low8 = {1'b0, acc_q[6:0]} + {1'b0, cur.operand[6:0]} + {7'h00, cin};

	// ==========================================
	// Execute
	logic bit_we, bit_val, byte_we, c_we, c_val, acc_we, arith, taken;
	logic [7:0] acc_val;
	always_comb begin
		bit_we = 1'b0;
		bit_val = 1'b0;
		byte_we = 1'b0;
		c_we = 1'b0;
		c_val = cy;
		acc_we = 1'b0;
		acc_val = acc_q;
		arith = 1'b0;
		taken = 1'b0;
		unique case (cur.op)
			bitproc_pkg::OP_SET_BIT: begin
				bit_we = 1'b1;
				bit_val = 1'b1;
			end
			bitproc_pkg::OP_CLR_BIT: bit_we = 1'b1;
			bitproc_pkg::OP_CPL_BIT: begin
				bit_we = 1'b1;
				bit_val = ~byte_old[bit_pos];
			end
			bitproc_pkg::OP_SET_C: begin
				c_we = 1'b1;
				c_val = 1'b1;
			end
			bitproc_pkg::OP_CLR_C: begin
				c_we = 1'b1;
				c_val = 1'b0;
			end
			bitproc_pkg::OP_CPL_C: begin
				c_we = 1'b1;
				c_val = ~cy;
			end
			bitproc_pkg::OP_MOV_C_BIT: begin
				c_we = 1'b1;
				c_val = bit_test;
			end
			bitproc_pkg::OP_MOV_BIT_C: begin
				bit_we = 1'b1;
				bit_val = cy;
			end
			bitproc_pkg::OP_AND_C_BIT: begin
				c_we = 1'b1;
				c_val = cy & bit_test;
			end
			bitproc_pkg::OP_AND_C_NBIT: begin
				c_we = 1'b1;
				c_val = cy & ~bit_test;
			end
			bitproc_pkg::OP_OR_C_BIT: begin
				c_we = 1'b1;
				c_val = cy | bit_test;
			end
			bitproc_pkg::OP_OR_C_NBIT: begin
				c_we = 1'b1;
				c_val = cy | ~bit_test;
			end
			bitproc_pkg::OP_JUMP_C: taken = cy;
			bitproc_pkg::OP_JUMP_NC: taken = ~cy;
			bitproc_pkg::OP_JUMP_BIT: taken = bit_test;
			bitproc_pkg::OP_JUMP_NBIT: taken = ~bit_test;
			bitproc_pkg::OP_JUMP_CLR: begin
				taken = bit_test;
				bit_we = bit_test;
			end
			bitproc_pkg::OP_SHORT_JUMP: taken = 1'b1;
			bitproc_pkg::OP_ROT_LEFT_C: begin
				acc_we = 1'b1;
				acc_val = {acc_q[6:0], cy};
				c_we = 1'b1;
				c_val = acc_q[7];
			end
			bitproc_pkg::OP_ROT_RIGHT_C: begin
				acc_we = 1'b1;
				acc_val = {cy, acc_q[7:1]};
				c_we = 1'b1;
				c_val = acc_q[0];
			end
			bitproc_pkg::OP_ADD_IMM, bitproc_pkg::OP_ADD_WITH_CARRY_OP_IMM: begin
				acc_we = 1'b1;
				acc_val = sum9[7:0];
				c_we = 1'b1;
				c_val = sum9[8];
				arith = 1'b1;
			end
			bitproc_pkg::OP_MOV_DIR_IMM: byte_we = 1'b1;
			default: ;
		endcase
	end

	// ==========================================
	// Write-back: a bit write rewrites its whole byte with the other bits kept
	wire [7:0] bit_mask = 8'h01 << bit_pos;
	wire [7:0] rmw_byte = (byte_old & ~bit_mask) | (bit_val ? bit_mask : 8'h00);
	wire [7:0] wr_addr = byte_we ? cur.bit_addr :
		(is_ram ? {bitproc_pkg::RAM_PAGE, ram_idx} : sfr_addr);
	wire [7:0] wr_val = byte_we ? cur.operand : rmw_byte;
	wire wr_en = exec & (bit_we | byte_we);
	wire wr_ram = wr_en & (wr_addr[7:4] == bitproc_pkg::RAM_PAGE);
	wire wr_psw = wr_en & (wr_addr == bitproc_pkg::ADDR_PSW);

	wire [7:0] acc_d = (wr_en & (wr_addr == bitproc_pkg::ADDR_ACC)) ? wr_val :
		((exec & acc_we) ? acc_val : acc_q);
	logic [7:0] psw_d;
	always_comb begin
		psw_d = wr_psw ? wr_val : psw_q;
		if (exec & arith) begin
			psw_d[bitproc_pkg::PSW_AC] = half5[4];
			psw_d[bitproc_pkg::PSW_OV] = sum9[8] ^ low8[7];
		end
		if (exec & c_we)
			psw_d[bitproc_pkg::PSW_CY] = c_val;
		psw_d[bitproc_pkg::PSW_P] = ^acc_d; // Parity follows the accumulator
	end

	// ==========================================
	// Program counter
	wire [15:0] seq_pc = pc_q + {14'h0000, len_of(cur.op)};
	wire [15:0] tgt_pc = seq_pc + {{8{cur.operand[7]}}, cur.operand};
	wire [15:0] pc_d = taken ? tgt_pc : seq_pc;

	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			state_q <= bitproc_pkg::ST_FIRST;
			hold_q <= '0;
			pc_q <= bitproc_pkg::PC_RESET;
			acc_q <= bitproc_pkg::BYTE_RESET;
			b_q <= bitproc_pkg::BYTE_RESET;
			psw_q <= bitproc_pkg::PSW_RESET;
			p1_q <= bitproc_pkg::P1_RESET;
			tcon_q <= bitproc_pkg::BYTE_RESET;
			done_q <= 1'b0;
			taken_q <= 1'b0;
			for (int i = 0; i < bitproc_pkg::RAM_BYTES; i++)
				ram_q[i] <= bitproc_pkg::BYTE_RESET;
		end else if (ce) begin
			state_q <= accept_two ? bitproc_pkg::ST_SECOND : bitproc_pkg::ST_FIRST;
			if (accept_two)
				hold_q <= instr;
			done_q <= exec;
			taken_q <= exec & taken;
			if (exec) begin
				pc_q <= pc_d;
				acc_q <= acc_d;
				psw_q <= psw_d;
			end
			if (wr_ram)
				ram_q[wr_addr[3:0]] <= wr_val;
			if (wr_en & (wr_addr == bitproc_pkg::ADDR_B))
				b_q <= wr_val;
			if (wr_en & (wr_addr == bitproc_pkg::ADDR_P1))
				p1_q <= wr_val;
			if (wr_en & (wr_addr == bitproc_pkg::ADDR_TCON))
				tcon_q <= wr_val;
		end
	end

	assign instr_ready = ~in_second;
	assign p1_out = p1_q;
	assign acc = acc_q;
	assign program_status_word = psw_q;
	assign carry_flag = psw_q[bitproc_pkg::PSW_CY];
	assign pc = pc_q;
	assign done = done_q;
	assign branch_taken = taken_q;

	// ==========================================
	// Checks
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_b);

	wire is_jump = cur.op inside {bitproc_pkg::OP_JUMP_C, bitproc_pkg::OP_JUMP_NC,
		bitproc_pkg::OP_JUMP_BIT, bitproc_pkg::OP_JUMP_NBIT, bitproc_pkg::OP_JUMP_CLR};
	sequence seq_park;
		ce && !done_q && in_second;
	endsequence
	sequence seq_finish;
		done_q && !in_second;
	endsequence

	chk_single_cycle: assert property (accept && !is_two(instr.op) |=> done_q)
		else $error("single-cycle op did not finish next cycle");
	// A low enable in the parked cycle only stretches the op, so it is checked when enable stays high
	chk_two_cycle_ops: assert property (accept_two ##1 ce |-> seq_park ##1 seq_finish)
		else $error("two-cycle op did not finish on the second cycle");
	chk_clear_ram_bit: assert property (exec && is_ram && cur.op == bitproc_pkg::OP_CLR_BIT
		|=> ram_q[$past(ram_idx)][$past(bit_pos)] == 1'b0)
		else $error("cleared RAM bit still set");
	chk_source_kept: assert property (exec && is_ram && cur.op inside {bitproc_pkg::OP_AND_C_BIT,
		bitproc_pkg::OP_AND_C_NBIT, bitproc_pkg::OP_OR_C_BIT, bitproc_pkg::OP_OR_C_NBIT}
		|=> ram_q[$past(ram_idx)] == $past(byte_old))
		else $error("logic op changed its source byte");
	chk_jbc_clears: assert property (exec && is_ram && cur.op == bitproc_pkg::OP_JUMP_CLR && bit_test
		|=> branch_taken && ram_q[$past(ram_idx)][$past(bit_pos)] == 1'b0)
		else $error("jump-and-clear left bit set or did not branch");
	chk_branch_target: assert property (exec && taken
		|=> pc_q == $past(pc_q) + {14'h0000, $past(len_of(cur.op))} + {{8{$past(cur.operand[7])}}, $past(cur.operand)})
		else $error("branch target wrong");
	chk_jump_fallthru: assert property (exec && is_jump && !taken |=> !branch_taken && pc_q == $past(seq_pc))
		else $error("untaken jump did not fall through");
	chk_psw_byte_carry: assert property (exec && byte_we && cur.bit_addr == bitproc_pkg::ADDR_PSW
		|=> carry_flag == $past(cur.operand[7]))
		else $error("status byte write did not load carry");
	chk_parity_tracks: assert property (psw_q[bitproc_pkg::PSW_P] == ^acc_q)
		else $error("parity flag does not match accumulator");

endmodule : bit_processor
`default_nettype wire

// [bench/boolean_bit_processor_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module boolean_bit_processor_tb;
	logic mclk = 1'b0;
	logic rst_b = 1'b0;
	logic ce = 1'b1;
	logic instr_valid = 1'b0;
	bitproc_pkg::instr_s instr = '0;
	logic [7:0] p1_pin = 8'h00;
	logic instr_ready, carry_flag, done, branch_taken;
	logic [7:0] p1_out, acc, program_status_word;
	logic [15:0] pc;
	logic [15:0] epc = 16'h0000;
	int fail_count = 0;
	int n_checks = 0;
	int cycles = 0;

	always #12.5 mclk = ~mclk;

	bit_processor u_bit_processor (.mclk(mclk), .rst_b(rst_b), .ce(ce), .instr_valid(instr_valid), .instr(instr),
		.instr_ready(instr_ready), .p1_pin(p1_pin), .p1_out(p1_out), .acc(acc), .program_status_word(program_status_word),
		.carry_flag(carry_flag), .pc(pc), .done(done), .branch_taken(branch_taken));

	// ==========================================
	// Checking and closing
	always @(posedge mclk) begin
		cycles <= cycles + 1;
		if (cycles == 4000) begin
			fail_count++;
			tally_and_finish();
		end
	end

	task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
		n_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
		end
	endtask : cmp

	task automatic cmpb(input logic got, input logic exp);
		cmp({15'h0000, got}, {15'h0000, exp});
	endtask : cmpb

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : tally_and_finish

	// ==========================================
	// One instruction: length, cycles, target and branch are judged every time
	task automatic exec(input bitproc_pkg::bit_op_e op, input logic [7:0] a, input logic [7:0] rel, input logic tk);
		int n;
		int w;
		int k;
		int i;
		n = (op inside {bitproc_pkg::OP_SET_C, bitproc_pkg::OP_CLR_C, bitproc_pkg::OP_CPL_C,
			bitproc_pkg::OP_ROT_LEFT_C, bitproc_pkg::OP_ROT_RIGHT_C}) ? 1 :
			(op inside {bitproc_pkg::OP_JUMP_BIT, bitproc_pkg::OP_JUMP_NBIT, bitproc_pkg::OP_JUMP_CLR,
			bitproc_pkg::OP_MOV_DIR_IMM}) ? 3 : 2;
		w = (op inside {bitproc_pkg::OP_MOV_BIT_C, bitproc_pkg::OP_MOV_DIR_IMM} ||
			(op >= bitproc_pkg::OP_JUMP_C && op <= bitproc_pkg::OP_SHORT_JUMP)) ? 2 : 1;
		epc = epc + 16'(n);
		if (tk) epc = epc + {{8{rel[7]}}, rel};
		@(posedge mclk);
		instr <= '{op: op, bit_addr: a, operand: rel};
		instr_valid <= 1'b1;
		@(posedge mclk);
		instr_valid <= 1'b0;
		k = 0;
		for (i = 1; i <= 4 && k == 0; i++) begin
			@(negedge mclk);
			if (done === 1'b1) k = i;
			else @(posedge mclk);
		end
		cmp(16'(k), 16'(w));
		cmp(pc, epc);
		cmpb(branch_taken, tk);
	endtask : exec

	// ==========================================
	// Scenarios
	task automatic t_state();
		logic [7:0] a;
		int i;
		for (i = 0; i < 5; i++) begin
			a = (i == 0) ? 8'h00 : (i == 1) ? 8'h7F : (i == 2) ? 8'hE3 : (i == 3) ? 8'h8C : 8'hF1;
			exec(bitproc_pkg::OP_SET_BIT, a, 8'h00, 1'b0);
			exec(bitproc_pkg::OP_JUMP_BIT, a, 8'h00, 1'b1);
			exec(bitproc_pkg::OP_CPL_BIT, a, 8'h00, 1'b0);
			exec(bitproc_pkg::OP_JUMP_NBIT, a, 8'h00, 1'b1);
		end
		exec(bitproc_pkg::OP_MOV_DIR_IMM, 8'h21, 8'h01, 1'b0);
		exec(bitproc_pkg::OP_JUMP_BIT, 8'h08, 8'h00, 1'b1);
		exec(bitproc_pkg::OP_JUMP_BIT, 8'h09, 8'h40, 1'b0);
		exec(bitproc_pkg::OP_SET_BIT, 8'hE3, 8'h00, 1'b0);
		exec(bitproc_pkg::OP_SET_BIT, 8'hE5, 8'h00, 1'b0);
		cmp(16'(acc), 16'h0028);
		exec(bitproc_pkg::OP_CLR_BIT, 8'hE3, 8'h00, 1'b0);
		cmp(16'(acc), 16'h0020);
		exec(bitproc_pkg::OP_SET_BIT, 8'hD5, 8'h00, 1'b0);
		cmpb(program_status_word[5], 1'b1);
		exec(bitproc_pkg::OP_CLR_BIT, 8'hD5, 8'h00, 1'b0);
		cmpb(program_status_word[5], 1'b0);
		$display("test state done");
	endtask : t_state

	task automatic t_carry();
		exec(bitproc_pkg::OP_SET_C, 8'h00, 8'h00, 1'b0);
		cmpb(program_status_word[7], 1'b1);
		exec(bitproc_pkg::OP_CPL_C, 8'h00, 8'h00, 1'b0);
		cmpb(carry_flag, 1'b0);
		exec(bitproc_pkg::OP_CPL_C, 8'h00, 8'h00, 1'b0);
		exec(bitproc_pkg::OP_CLR_C, 8'h00, 8'h00, 1'b0);
		cmpb(carry_flag, 1'b0);
		exec(bitproc_pkg::OP_MOV_DIR_IMM, 8'hD0, 8'h80, 1'b0);
		cmpb(carry_flag, 1'b1);
		exec(bitproc_pkg::OP_CLR_BIT, 8'hD7, 8'h00, 1'b0);
		cmpb(carry_flag, 1'b0);
		$display("test carry done");
	endtask : t_carry

	task automatic t_logic();
		bitproc_pkg::bit_op_e lops[4] = '{bitproc_pkg::OP_AND_C_BIT, bitproc_pkg::OP_AND_C_NBIT,
			bitproc_pkg::OP_OR_C_BIT, bitproc_pkg::OP_OR_C_NBIT};
		logic b;
		logic e;
		int i;
		for (i = 0; i < 16; i++) begin
			b = i[2] ? ~i[1] : i[1];
			e = i[3] ? (i[0] | b) : (i[0] & b);
			exec(i[0] ? bitproc_pkg::OP_SET_C : bitproc_pkg::OP_CLR_C, 8'h00, 8'h00, 1'b0);
			exec(i[1] ? bitproc_pkg::OP_SET_BIT : bitproc_pkg::OP_CLR_BIT, 8'h12, 8'h00, 1'b0);
			exec(lops[i / 4], 8'h12, 8'h00, 1'b0);
			cmpb(carry_flag, e);
			exec(bitproc_pkg::OP_JUMP_BIT, 8'h12, 8'h00, i[1]);
		end
		exec(bitproc_pkg::OP_SET_BIT, 8'h20, 8'h00, 1'b0);
		exec(bitproc_pkg::OP_CLR_C, 8'h00, 8'h00, 1'b0);
		exec(bitproc_pkg::OP_MOV_C_BIT, 8'h20, 8'h00, 1'b0);
		cmpb(carry_flag, 1'b1);
		exec(bitproc_pkg::OP_MOV_BIT_C, 8'h21, 8'h00, 1'b0);
		exec(bitproc_pkg::OP_JUMP_BIT, 8'h21, 8'h00, 1'b1);
		$display("test logic done");
	endtask : t_logic

	task automatic t_jump();
		exec(bitproc_pkg::OP_SET_C, 8'h00, 8'h00, 1'b0);
		exec(bitproc_pkg::OP_JUMP_C, 8'h00, 8'h80, 1'b1);
		exec(bitproc_pkg::OP_JUMP_NC, 8'h00, 8'h40, 1'b0);
		exec(bitproc_pkg::OP_CLR_C, 8'h00, 8'h00, 1'b0);
		exec(bitproc_pkg::OP_JUMP_C, 8'h00, 8'h40, 1'b0);
		exec(bitproc_pkg::OP_JUMP_NC, 8'h00, 8'h7F, 1'b1);
		exec(bitproc_pkg::OP_SET_BIT, 8'h30, 8'h00, 1'b0);
		exec(bitproc_pkg::OP_JUMP_NBIT, 8'h30, 8'h10, 1'b0);
		exec(bitproc_pkg::OP_JUMP_CLR, 8'h30, 8'hF0, 1'b1);
		exec(bitproc_pkg::OP_JUMP_CLR, 8'h30, 8'h10, 1'b0);
		exec(bitproc_pkg::OP_JUMP_NBIT, 8'h30, 8'h05, 1'b1);
		exec(bitproc_pkg::OP_SHORT_JUMP, 8'h00, 8'hFE, 1'b1);
		$display("test jump done");
	endtask : t_jump

	task automatic t_misc();
		exec(bitproc_pkg::OP_CPL_BIT, 8'h92, 8'h00, 1'b0);
		cmp(16'(p1_out), 16'h00FB);
		@(posedge mclk);
		p1_pin <= 8'h08;
		exec(bitproc_pkg::OP_JUMP_BIT, 8'h93, 8'h00, 1'b1);
		exec(bitproc_pkg::OP_JUMP_BIT, 8'h94, 8'h40, 1'b0);
		exec(bitproc_pkg::OP_MOV_DIR_IMM, 8'hE0, 8'h7F, 1'b0);
		exec(bitproc_pkg::OP_JUMP_BIT, 8'hD0, 8'h00, 1'b1);
		exec(bitproc_pkg::OP_CLR_C, 8'h00, 8'h00, 1'b0);
		exec(bitproc_pkg::OP_ADD_IMM, 8'h00, 8'h01, 1'b0);
		cmp(16'(acc), 16'h0080);
		exec(bitproc_pkg::OP_JUMP_BIT, 8'hD2, 8'h00, 1'b1);
		exec(bitproc_pkg::OP_ROT_LEFT_C, 8'h00, 8'h00, 1'b0);
		cmp(16'({carry_flag, acc}), 16'h0100);
		exec(bitproc_pkg::OP_ADD_WITH_CARRY_OP_IMM, 8'h00, 8'h01, 1'b0);
		cmp(16'({carry_flag, acc}), 16'h0002);
		exec(bitproc_pkg::OP_ROT_RIGHT_C, 8'h00, 8'h00, 1'b0);
		cmp(16'({carry_flag, acc}), 16'h0001);
		$display("test misc done");
	endtask : t_misc

	// Enable dropped in the parked cycle: the jump must wait, then land as usual
	task automatic t_hold();
		epc = epc + 16'h0012;
		@(posedge mclk);
		instr <= '{op: bitproc_pkg::OP_SHORT_JUMP, bit_addr: 8'h00, operand: 8'h10};
		instr_valid <= 1'b1;
		@(posedge mclk);
		instr_valid <= 1'b0;
		ce <= 1'b0;
		repeat (2) @(posedge mclk);
		@(negedge mclk);
		cmpb(instr_ready, 1'b0);
		cmpb(done, 1'b0);
		@(posedge mclk);
		ce <= 1'b1;
		@(posedge mclk);
		@(negedge mclk);
		cmpb(done, 1'b1);
		cmpb(instr_ready, 1'b1);
		cmpb(branch_taken, 1'b1);
		cmp(pc, epc);
		$display("test hold done");
	endtask : t_hold

	initial begin
		repeat (16) @(posedge mclk);
		rst_b <= 1'b1;
		t_state();
		t_carry();
		t_logic();
		t_jump();
		t_misc();
		t_hold();
		tally_and_finish();
	end
endmodule : boolean_bit_processor_tb
`default_nettype wire
